//--- rtl/adc_result_formatter.sv
// register block and bus slave of the 12-bit result formatter
//
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "adcf_defs.svh"

module adc_result_formatter #(
  parameter int ADDR_W      = 4,
  parameter int RESULT_BITS = 12
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [ADDR_W-1:0]      awaddr,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  output adcf_pkg::axi_resp_type      bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  input  wire logic [ADDR_W-1:0]      araddr,
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic      [31:0]            rdata,
  output adcf_pkg::axi_resp_type      rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  output logic                        converter_enable,
  output logic      [4:0]             channel_select,
  output logic                        conv_start,
  input  wire logic                   conv_done,
  input  wire logic [RESULT_BITS-1:0] conv_magnitude,
  input  wire logic                   conv_sign
);
  import adcf_pkg::*;

  if (ADDR_W < 4) begin : g_bad_addr
    $error("ADDR_W must be at least 4");
  end
  if (RESULT_BITS != 12) begin : g_bad_width
    $error("RESULT_BITS must be 12");
  end

  // write channel state
  logic               aw_got_q, aw_got_d;
  logic [ADDR_W-1:0]  aw_addr_q, aw_addr_d;
  logic               w_got_q, w_got_d;
  logic [31:0]        w_data_q, w_data_d;
  logic [3:0]         w_strb_q, w_strb_d;
  logic               bvalid_q, bvalid_d;
  axi_resp_type       bresp_q, bresp_d;

  // read channel state
  logic               rvalid_q, rvalid_d;
  logic [31:0]        rdata_q, rdata_d;
  axi_resp_type       rresp_q, rresp_d;

  // control and result state
  logic               en_q, en_d;
  logic [4:0]         chs_q, chs_d;
  logic               fmt_q, fmt_d;
  logic [7:0]         high_q, high_d;
  logic [7:0]         low_q, low_d;

  logic               aw_fire;
  logic               w_fire;
  logic               ar_fire;
  logic               do_write;
  logic [ADDR_W-1:0]  wr_addr;
  logic [31:0]        wr_data;
  logic               wr_lane;
  logic               wr_ctrl;
  logic               wr_high;
  logic               wr_low;
  logic               wr_mapped;
  logic               rd_mapped;
  logic               start_req;
  logic               busy;
  logic               conv_take;
  logic [7:0]         pk_high;
  logic [7:0]         pk_low;

  assign awready  = !aw_got_q && !bvalid_q;
  assign wready   = !w_got_q && !bvalid_q;
  assign arready  = !rvalid_q;
  assign aw_fire  = awvalid && awready;
  assign w_fire   = wvalid && wready;
  assign ar_fire  = arvalid && arready;
  assign do_write = (aw_got_q || aw_fire) && (w_got_q || w_fire);
  assign wr_addr  = aw_got_q ? aw_addr_q : awaddr;
  assign wr_data  = w_got_q ? w_data_q : wdata;
  assign wr_lane  = w_got_q ? w_strb_q[`ADCF_WRITE_LANE] : wstrb[`ADCF_WRITE_LANE];

  always_comb begin
    wr_mapped = (wr_addr == ADDR_W'(`ADCF_CTRL_OFF)) ||
                (wr_addr == ADDR_W'(`ADCF_HIGH_OFF)) ||
                (wr_addr == ADDR_W'(`ADCF_LOW_OFF));
    rd_mapped = (araddr == ADDR_W'(`ADCF_CTRL_OFF)) ||
                (araddr == ADDR_W'(`ADCF_HIGH_OFF)) ||
                (araddr == ADDR_W'(`ADCF_LOW_OFF));
    wr_ctrl   = do_write && wr_lane && (wr_addr == ADDR_W'(`ADCF_CTRL_OFF));
    wr_high   = do_write && wr_lane && (wr_addr == ADDR_W'(`ADCF_HIGH_OFF));
    wr_low    = do_write && wr_lane && (wr_addr == ADDR_W'(`ADCF_LOW_OFF));
  end

  // address and data are taken in either order; the answer follows both
  always_comb begin
    aw_got_d  = aw_got_q;
    aw_addr_d = aw_addr_q;
    w_got_d   = w_got_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    if (aw_fire) begin
      aw_got_d  = 1'b1;
      aw_addr_d = awaddr;
    end
    if (w_fire) begin
      w_got_d  = 1'b1;
      w_data_d = wdata;
      w_strb_d = wstrb;
    end
    if (do_write) begin
      aw_got_d = 1'b0;
      w_got_d  = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = wr_mapped ? `ADCF_RESP_OKAY : `ADCF_RESP_SLVERR;
    end else if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q  <= 1'b0;
      aw_addr_q <= '0;
      w_got_q   <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `ADCF_RESP_OKAY;
    end else begin
      aw_got_q  <= aw_got_d;
      aw_addr_q <= aw_addr_d;
      w_got_q   <= w_got_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
    end
  end

  // control register: enable, channel, layout select, start request
  always_comb begin
    en_d      = en_q;
    chs_d     = chs_q;
    fmt_d     = fmt_q;
    start_req = 1'b0;
    if (wr_ctrl) begin
      en_d      = wr_data[`ADCF_EN_BIT];
      chs_d     = wr_data[`ADCF_CHS_MSB:`ADCF_CHS_LSB];
      fmt_d     = wr_data[`ADCF_FMT_BIT];
      start_req = wr_data[`ADCF_GO_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_q  <= 1'((`ADCF_CTRL_RST) >> `ADCF_EN_BIT);
      chs_q <= `ADCF_CHS_RST;
      fmt_q <= 1'((`ADCF_CTRL_RST) >> `ADCF_FMT_BIT);
    end else begin
      en_q  <= en_d;
      chs_q <= chs_d;
      fmt_q <= fmt_d;
    end
  end

  // writing 0 to the status bit does not abort; only clearing enable does
  conv_sequencer u_seq (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .start_req  (start_req),
    .enable     (en_d),
    .conv_done  (conv_done),
    .busy       (busy),
    .conv_start (conv_start),
    .conv_take  (conv_take)
  );

  result_packer #(
    .RESULT_BITS (RESULT_BITS)
  ) u_pack (
    .result_format_select (fmt_q),
    .magnitude            (conv_magnitude),
    .result_sign          (conv_sign),
    .high_byte            (pk_high),
    .low_byte             (pk_low)
  );

  // completion beats a software write to the same byte in the same cycle
  always_comb begin
    high_d = high_q;
    low_d  = low_q;
    if (wr_high) begin
      high_d = wr_data[7:0];
    end
    if (wr_low) begin
      low_d = wr_data[7:0];
    end
    if (conv_take) begin
      high_d = pk_high;
      low_d  = pk_low;
    end
  end

  // no reset on purpose: contents survive every reset, unknown at power-up
  always_ff @(posedge aclk) begin
    high_q <= high_d;
    low_q  <= low_d;
  end

  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (ar_fire) begin
      rvalid_d = 1'b1;
      rresp_d  = rd_mapped ? `ADCF_RESP_OKAY : `ADCF_RESP_SLVERR;
      rdata_d  = 32'h0000_0000;
      if (araddr == ADDR_W'(`ADCF_CTRL_OFF)) begin
        rdata_d[`ADCF_EN_BIT]                 = en_q;
        rdata_d[`ADCF_GO_BIT]                 = busy;
        rdata_d[`ADCF_CHS_MSB:`ADCF_CHS_LSB]  = chs_q;
        rdata_d[`ADCF_FMT_BIT]                = fmt_q;
      end else if (araddr == ADDR_W'(`ADCF_HIGH_OFF)) begin
        rdata_d[7:0] = high_q;
      end else if (araddr == ADDR_W'(`ADCF_LOW_OFF)) begin
        rdata_d[7:0] = low_q;
      end
    end else if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `ADCF_RESP_OKAY;
    end else begin
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
    end
  end

  assign bvalid           = bvalid_q;
  assign bresp            = bresp_q;
  assign rvalid           = rvalid_q;
  assign rdata            = rdata_q;
  assign rresp            = rresp_q;
  assign converter_enable = en_q;
  assign channel_select   = chs_q;

  // expected two's complement value, independent of the packer
  logic [11:0] exp_twos;
  logic        exp_neg;
  assign exp_neg  = conv_sign && (conv_magnitude != 12'h000);
  assign exp_twos = exp_neg ? 12'(~conv_magnitude + 12'h001) : conv_magnitude;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_layout0_high: assert property (
    (conv_take && !fmt_q) |=> high_q == $past(conv_magnitude[11:4]))
    else $error("layout 0 high byte does not hold result bits 11..4");
  a_layout0_lowmag: assert property (
    (conv_take && !fmt_q) |=> low_q[7:4] == $past(conv_magnitude[3:0]))
    else $error("layout 0 low byte bits 7..4 wrong");
  a_layout0_zeros: assert property (
    (conv_take && !fmt_q) |=> low_q[3:1] == 3'h0)
    else $error("layout 0 low byte bits 3..1 not zero");
  a_layout0_sign: assert property (
    (conv_take && !fmt_q) |=> low_q[0] == $past(conv_sign))
    else $error("layout 0 sign bit wrong");
  a_layout1_ext: assert property (
    (conv_take && fmt_q) |=> high_q[7:4] == {4{$past(exp_neg)}})
    else $error("layout 1 sign extension wrong");
  a_layout1_upper: assert property (
    (conv_take && fmt_q) |=> high_q[3:0] == $past(exp_twos[11:8]))
    else $error("layout 1 high byte bits 3..0 wrong");
  a_layout1_lower: assert property (
    (conv_take && fmt_q) |=> low_q == $past(exp_twos[7:0]))
    else $error("layout 1 low byte wrong");
  a_twos_value: assert property (
    (conv_take && fmt_q && conv_sign && conv_magnitude != 12'h000)
      |=> $signed({high_q[3:0], low_q}) < 0)
    else $error("negative result not negative in two's complement");
  a_result_kept: assert property (
    (!conv_take && !wr_high && !wr_low) |=> $stable(high_q) && $stable(low_q))
    else $error("result bytes changed without cause");
  a_status_read: assert property (
    (ar_fire && araddr == ADDR_W'(`ADCF_CTRL_OFF))
      |=> rvalid && rdata[`ADCF_GO_BIT] == $past(busy))
    else $error("status bit read does not show conversion state");
  a_write_answer: assert property (
    do_write |=> bvalid && (bresp == `ADCF_RESP_OKAY) == $past(wr_mapped))
    else $error("write answer missing or wrong");
  a_bvalid_hold: assert property (
    (bvalid && !bready) |=> bvalid && $stable(bresp))
    else $error("write answer dropped before bready");
  a_rvalid_hold: assert property (
    (rvalid && !rready) |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer changed before rready");
  a_take_both: assert property (
    conv_take |=> high_q == $past(pk_high) && low_q == $past(pk_low))
    else $error("result bytes not updated together at completion");

  c_layout0_conv: cover property (conv_take && !fmt_q);
  c_layout1_negative: cover property (conv_take && fmt_q && conv_sign);
  c_sw_result_write: cover property (wr_high ##[1:20] wr_low);
  c_unmapped_read: cover property (ar_fire && !rd_mapped);

endmodule : adc_result_formatter

//--- rtl/adcf_defs.svh
// offsets, field positions, reset values and bus answers of the result formatter
// Notes on behaviour
// - layout 0: result bits 11..4 go to high byte, msb at bit 7
// - layout 0: result bits 3..0 go to low byte bits 7..4
// - layout 0: low byte bits 3..1 are written as zero on each conversion
// - layout 0: low byte bit 0 holds the result sign
// - layout 1: high byte bits 7..4 all carry the sign, zero for a negative zero
// - layout 1: result bits 11..8 go to high byte bits 3..0
// - layout 1: result bits 7..0 fill the whole low byte
// - both result bytes are read/write, unreset, kept across all resets
// - select 1 gives two's complement, select 0 sign and magnitude
// - writing 1 to the status bit starts; hardware clears it when done
`ifndef ADCF_DEFS_SVH
`define ADCF_DEFS_SVH

`define ADCF_CTRL_OFF    4'h0
`define ADCF_HIGH_OFF    4'h4
`define ADCF_LOW_OFF     4'h8

`define ADCF_EN_BIT      0
`define ADCF_GO_BIT      1
`define ADCF_CHS_LSB     2
`define ADCF_CHS_MSB     6
`define ADCF_FMT_BIT     7
`define ADCF_WRITE_LANE  0

`define ADCF_CTRL_RST    8'h00
`define ADCF_CHS_RST     5'h00
`define ADCF_RESP_OKAY   2'h0
`define ADCF_RESP_SLVERR 2'h2

`endif

//--- rtl/adcf_pkg.sv
// types shared by the result formatter files
package adcf_pkg;

  typedef logic [1:0] axi_resp_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } conv_state_type;

endpackage : adcf_pkg

//--- rtl/conv_sequencer.sv
// conversion status flag: start on software request, clear on completion
`timescale 1ns/1ps
`include "adcf_defs.svh"

module conv_sequencer (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic start_req,
  input  wire logic enable,
  input  wire logic conv_done,
  output logic      busy,
  output logic      conv_start,
  output logic      conv_take
);
  import adcf_pkg::*;

  conv_state_type state_q, state_d;
  logic           start_q, start_d;

  always_comb begin
    state_d = state_q;
    start_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (start_req && enable) begin
          state_d = ST_BUSY;
          start_d = 1'b1;
        end
      end
      ST_BUSY: begin
        if (!enable) begin
          state_d = ST_IDLE;
        end else if (conv_done) begin
          state_d = ST_IDLE;
        end
        // a new start in the completion cycle wins over the clear
        if (enable && conv_done && start_req) begin
          state_d = ST_BUSY;
          start_d = 1'b1;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      start_q <= 1'b0;
    end else begin
      state_q <= state_d;
      start_q <= start_d;
    end
  end

  assign busy       = (state_q == ST_BUSY);
  assign conv_start = start_q;
  assign conv_take  = (state_q == ST_BUSY) && conv_done && enable;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_start_sets_busy: assert property (
    (!busy && start_req && enable) |=> (busy && conv_start) ##1 !conv_start)
    else $error("start request did not raise busy with a one-cycle start");
  a_done_clears_busy: assert property (
    (busy && conv_done && enable && !start_req) |=> !busy && !conv_start)
    else $error("completion did not clear the status flag");

endmodule : conv_sequencer

//--- rtl/result_packer.sv
// places magnitude and sign into the two result bytes for either layout
`timescale 1ns/1ps
`include "adcf_defs.svh"

module result_packer #(
  parameter int RESULT_BITS = 12
) (
  input  wire logic                   result_format_select,
  input  wire logic [RESULT_BITS-1:0] magnitude,
  input  wire logic                   result_sign,
  output logic      [7:0]             high_byte,
  output logic      [7:0]             low_byte
);
  import adcf_pkg::*;

  if (RESULT_BITS != 12) begin : g_bad_width
    $error("result_packer serves only a 12-bit result");
  end

  logic [11:0] twos;
  logic        neg;

  always_comb begin
    // a negative zero must not turn into -4096
    neg  = result_sign && (magnitude != 12'h000);
    twos = neg ? 12'(~magnitude + 12'h001) : magnitude;
    if (result_format_select) begin
      high_byte = {{4{neg}}, twos[11:8]};
      low_byte  = twos[7:0];
    end else begin
      high_byte = magnitude[11:4];
      low_byte  = {magnitude[3:0], 3'b000, result_sign};
    end
  end

endmodule : result_packer

//--- testbench/testbench.sv
// self-checking bench for the result formatter register block
`timescale 1ns/1ps
`include "adcf_defs.svh"

`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end

module testbench;
  import adcf_pkg::*;

  // channel settling wait before a start; any span works for a digital model
  localparam int ACQ_CYCLES = 50;

  logic         aclk;
  logic         aresetn;
  logic [3:0]   awaddr;
  logic         awvalid;
  logic         awready;
  logic [31:0]  wdata;
  logic [3:0]   wstrb;
  logic         wvalid;
  logic         wready;
  axi_resp_type bresp;
  logic         bvalid;
  logic         bready;
  logic [3:0]   araddr;
  logic         arvalid;
  logic         arready;
  logic [31:0]  rdata;
  axi_resp_type rresp;
  logic         rvalid;
  logic         rready;
  logic         converter_enable;
  logic [4:0]   channel_select;
  logic         conv_start;
  logic         conv_done;
  logic [11:0]  conv_magnitude;
  logic         conv_sign;
  int           failures;
  int           total_checks;
  int           starts;

  adc_result_formatter adc_result_formatter_inst (
    .aclk             (aclk),
    .aresetn          (aresetn),
    .awaddr           (awaddr),
    .awvalid          (awvalid),
    .awready          (awready),
    .wdata            (wdata),
    .wstrb            (wstrb),
    .wvalid           (wvalid),
    .wready           (wready),
    .bresp            (bresp),
    .bvalid           (bvalid),
    .bready           (bready),
    .araddr           (araddr),
    .arvalid          (arvalid),
    .arready          (arready),
    .rdata            (rdata),
    .rresp            (rresp),
    .rvalid           (rvalid),
    .rready           (rready),
    .converter_enable (converter_enable),
    .channel_select   (channel_select),
    .conv_start       (conv_start),
    .conv_done        (conv_done),
    .conv_magnitude   (conv_magnitude),
    .conv_sign        (conv_sign)
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // counted at the edge so a one-cycle pulse is never missed
  always @(posedge aclk) begin
    if (conv_start === 1'b1) starts++;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  task automatic wr(input logic [3:0] a, input logic [7:0] d, input axi_resp_type er);
    logic aw_ok;
    logic w_ok;
    int   n;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    n     = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_ok && w_ok) && n < 100) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1 && n < 200) begin
      @(posedge aclk);
      n++;
    end
    `CHK("bvalid", 1'b1, bvalid)
    `CHK("bresp", er, bresp)
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] ed, input axi_resp_type er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (rvalid !== 1'b1 && n < 200) begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end
    `CHK("rvalid", 1'b1, rvalid)
    `CHK("rdata", ed, rdata)
    `CHK("rresp", er, rresp)
    rready <= 1'b0;
  endtask : rd

  // one-cycle completion pulse; data inverted afterwards so stale capture shows
  task automatic fin(input logic [11:0] m, input logic s);
    @(posedge aclk);
    conv_magnitude <= m;
    conv_sign      <= s;
    conv_done      <= 1'b1;
    @(posedge aclk);
    conv_done      <= 1'b0;
    conv_magnitude <= ~m;
    conv_sign      <= ~s;
  endtask : fin

  task automatic t_sign_mag;
    int s0;
    wr(`ADCF_CTRL_OFF, 8'h55, `ADCF_RESP_OKAY);
    repeat (ACQ_CYCLES) @(posedge aclk);
    `CHK("channel", 5'h15, channel_select)
    `CHK("enable", 1'b1, converter_enable)
    wr(`ADCF_LOW_OFF, 8'hFF, `ADCF_RESP_OKAY);
    s0 = starts;
    wr(`ADCF_CTRL_OFF, 8'h57, `ADCF_RESP_OKAY);
    rd(`ADCF_CTRL_OFF, 32'h0000_0057, `ADCF_RESP_OKAY);
    `CHK("start pulses", s0 + 1, starts)
    fin(12'hABC, 1'b1);
    rd(`ADCF_HIGH_OFF, 32'h0000_00AB, `ADCF_RESP_OKAY);
    rd(`ADCF_LOW_OFF, 32'h0000_00C1, `ADCF_RESP_OKAY);
    rd(`ADCF_CTRL_OFF, 32'h0000_0055, `ADCF_RESP_OKAY);
    $display("test sign_mag done");
  endtask : t_sign_mag

  // the channel moves back to 0 here, so settle before the first start
  task automatic t_twos;
    wr(`ADCF_CTRL_OFF, 8'h81, `ADCF_RESP_OKAY);
    repeat (ACQ_CYCLES) @(posedge aclk);
    wr(`ADCF_CTRL_OFF, 8'h83, `ADCF_RESP_OKAY);
    fin(12'h123, 1'b1);
    rd(`ADCF_HIGH_OFF, 32'h0000_00FE, `ADCF_RESP_OKAY);
    rd(`ADCF_LOW_OFF, 32'h0000_00DD, `ADCF_RESP_OKAY);
    wr(`ADCF_CTRL_OFF, 8'h83, `ADCF_RESP_OKAY);
    fin(12'h7A5, 1'b0);
    rd(`ADCF_HIGH_OFF, 32'h0000_0007, `ADCF_RESP_OKAY);
    rd(`ADCF_LOW_OFF, 32'h0000_00A5, `ADCF_RESP_OKAY);
    $display("test twos done");
  endtask : t_twos

  // layout changed while busy: the value at completion must win
  task automatic t_select_at_done;
    wr(`ADCF_CTRL_OFF, 8'h83, `ADCF_RESP_OKAY);
    wr(`ADCF_CTRL_OFF, 8'h01, `ADCF_RESP_OKAY);
    rd(`ADCF_CTRL_OFF, 32'h0000_0003, `ADCF_RESP_OKAY);
    fin(12'h123, 1'b1);
    rd(`ADCF_HIGH_OFF, 32'h0000_0012, `ADCF_RESP_OKAY);
    rd(`ADCF_LOW_OFF, 32'h0000_0031, `ADCF_RESP_OKAY);
    $display("test select_at_done done");
  endtask : t_select_at_done

  task automatic t_regs;
    wr(`ADCF_HIGH_OFF, 8'h5A, `ADCF_RESP_OKAY);
    wr(`ADCF_LOW_OFF, 8'hA5, `ADCF_RESP_OKAY);
    rd(`ADCF_HIGH_OFF, 32'h0000_005A, `ADCF_RESP_OKAY);
    rd(`ADCF_LOW_OFF, 32'h0000_00A5, `ADCF_RESP_OKAY);
    wr(4'hC, 8'h77, `ADCF_RESP_SLVERR);
    rd(4'hC, 32'h0000_0000, `ADCF_RESP_SLVERR);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    `CHK("enable after reset", 1'b0, converter_enable)
    rd(`ADCF_HIGH_OFF, 32'h0000_005A, `ADCF_RESP_OKAY);
    rd(`ADCF_LOW_OFF, 32'h0000_00A5, `ADCF_RESP_OKAY);
    // clearing enable abandons the conversion; the late completion is ignored
    wr(`ADCF_CTRL_OFF, 8'h03, `ADCF_RESP_OKAY);
    wr(`ADCF_CTRL_OFF, 8'h00, `ADCF_RESP_OKAY);
    rd(`ADCF_CTRL_OFF, 32'h0000_0000, `ADCF_RESP_OKAY);
    fin(12'h111, 1'b0);
    rd(`ADCF_HIGH_OFF, 32'h0000_005A, `ADCF_RESP_OKAY);
    rd(`ADCF_LOW_OFF, 32'h0000_00A5, `ADCF_RESP_OKAY);
    $display("test regs done");
  endtask : t_regs

  initial begin
    failures       = 0;
    total_checks   = 0;
    starts         = 0;
    aresetn        = 1'b0;
    awaddr         = 4'h0;
    awvalid        = 1'b0;
    wdata          = 32'h0000_0000;
    wstrb          = 4'h1;
    wvalid         = 1'b0;
    bready         = 1'b0;
    araddr         = 4'h0;
    arvalid        = 1'b0;
    rready         = 1'b0;
    conv_done      = 1'b0;
    conv_magnitude = 12'h000;
    conv_sign      = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_sign_mag();
    t_twos();
    t_select_at_done();
    t_regs();
    end_sim();
  end

  // the whole run needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    end_sim();
  end

endmodule : testbench
